// ### hw/ebi_top.sv
// e1 block interrupt summary, enables and receive alarm status
// Overview of operation
// - slip summary set while pending, read clears
// - alarm summary set while pending, read clears
// - framer summary set while pending, read clears
// - bit 7 gates the spare bit unit
// - alarm block enable gates alarm interrupts at irq_pin, not at irq
// - framer block enable gates framer interrupts at irq_pin, not at irq
// - pin needs source and block enable
// - out of frame after criterion errored patterns
// - ais declared after two all-ones frames
// - ais cleared by >2 zeros two frames
// - sticky yellow change flag, read clears
// - yellow declared when ts16 y bit one
// - loss declared after 175 zero bits
// - loss cleared only by ones density over a 175-bit window
// - enable bit 5 gates yellow change irq
// - hdlc summary set while pending, read clears
`timescale 1ns/1ns
module ebi_top (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [13:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic slip_req,
	input wire logic framer_req,
	input wire logic hdlc_req,
	input wire logic spare_req,
	input wire logic alarm_src_req,
	input wire logic bit_strobe,
	input wire logic rx_bit,
	input wire logic frame_start,
	input wire logic fas_errored,
	input wire logic fas_check,
	input wire logic ts16_fr0,
	input wire logic ts16_y,
	output logic irq_pin,
	output logic irq
);
	logic [2:0] sync_a;
	logic [2:0] sync_b;
	logic [1:0] sync_c;
	logic [2:0] state_q;
	logic [2:0] state_chg;
	logic s_strobe;
	logic s_bit;
	logic s_frame;
	logic [7:0] block_pending_enable;
	logic [7:0] alarm_en;
	logic [2:0] alignment_loss_criterion;
	logic [7:0] irq_status;
	logic [7:0] irq_mask;
	logic slip_pend;
	logic framer_pend;
	logic hdlc_pend;
	logic spare_pend;
	logic alarm_pend;
	logic out_of_frame_now;
	logic [2:0] fas_err_cnt;
	logic all_ones_defect_now;
	logic [1:0] ais_frames;
	logic [1:0] zero_cnt;
	logic frame_zeros;
	logic myel_now;
	logic multiframe_remote_alarm_change;
	logic signal_loss_now;
	logic [7:0] zero_run;
	logic [7:0] win_cnt;
	logic [7:0] ones_cnt;
	logic rd;
	logic wr;
	logic access;
	logic [11:0] idx;
	logic [7:0] summary;
	logic alarm_any;
	logic next_irq_pin;
	logic [7:0] rd_byte;
	logic hit;
	logic [7:0] events;

	function automatic logic reg_read(input logic [11:0] a);
		return rd && (idx == a);
	endfunction : reg_read

	function automatic logic reg_write(input logic [11:0] a);
		return wr && (idx == a);
	endfunction : reg_write

	// external serial signals come from the line clock domain
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync_a <= 3'h0;
			sync_b <= 3'h0;
			sync_c <= 2'h0;
		end else if (clk_en) begin
			sync_a <= {frame_start, rx_bit, bit_strobe};
			sync_b <= sync_a;
			sync_c <= {sync_b[2], sync_b[0]};
		end
	end
	// strobes stand for several clocks, so act only on their rising edge
	assign s_strobe = sync_b[0] && !sync_c[0];
	assign s_bit = sync_b[1];
	assign s_frame = sync_b[2] && !sync_c[1];

	assign access = psel && penable;
	assign rd = access && !pwrite && clk_en;
	assign wr = access && pwrite && clk_en;
	assign idx = paddr[13:2];

	// pending flags: set wins over the read that clears
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			slip_pend <= 1'b0;
		end else if (clk_en) begin
			slip_pend <= slip_req ||
				(slip_pend && !reg_read(ebi_pkg::IDX_SLIP_ST));
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			framer_pend <= 1'b0;
		end else if (clk_en) begin
			framer_pend <= framer_req ||
				(framer_pend && !reg_read(ebi_pkg::IDX_FRAMER_ST));
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hdlc_pend <= 1'b0;
		end else if (clk_en) begin
			hdlc_pend <= hdlc_req ||
				(hdlc_pend && !reg_read(ebi_pkg::IDX_HDLC_ST));
		end
	end

	// spare bit unit holds its own request; this bit only mirrors it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			spare_pend <= 1'b0;
		end else if (clk_en) begin
			spare_pend <= spare_req;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			alarm_pend <= 1'b0;
		end else if (clk_en) begin
			alarm_pend <= alarm_src_req || alarm_any ||
				(alarm_pend && !(reg_read(ebi_pkg::IDX_ALARM) ||
				reg_read(ebi_pkg::IDX_ALARM_ST2) ||
				reg_read(ebi_pkg::IDX_ALARM_ST3)));
		end
	end

	// out of frame: count consecutive errored alignment words
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fas_err_cnt <= 3'h0;
			out_of_frame_now <= 1'b0;
		end else if (clk_en && fas_check) begin
			if (!fas_errored) begin
				fas_err_cnt <= 3'h0;
				out_of_frame_now <= 1'b0;
			end else if (fas_err_cnt + 3'h1 >= alignment_loss_criterion) begin
				out_of_frame_now <= 1'b1;
			end else begin
				fas_err_cnt <= fas_err_cnt + 3'h1;
			end
		end
	end

	// ais: per frame zero count, two frames to declare or clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			zero_cnt <= 2'h0;
			frame_zeros <= 1'b0;
			ais_frames <= 2'h0;
			all_ones_defect_now <= 1'b0;
		end else if (clk_en) begin
			if (s_frame) begin
				zero_cnt <= 2'h0;
				// a frame that agrees with the present state restarts the count
				if (frame_zeros != all_ones_defect_now) begin
					ais_frames <= 2'h0;
				end else if (ais_frames + 2'h1 >= ebi_pkg::AIS_FRAMES) begin
					all_ones_defect_now <= !all_ones_defect_now;
					ais_frames <= 2'h0;
				end else begin
					ais_frames <= ais_frames + 2'h1;
				end
				frame_zeros <= 1'b0;
			end else if (s_strobe && !s_bit) begin
				if (zero_cnt == ebi_pkg::AIS_ZERO_LIMIT) begin
					frame_zeros <= 1'b1;
				end else begin
					zero_cnt <= zero_cnt + 2'h1;
				end
			end
		end
	end

	// loss of signal: zero run and ones density over 175-bit window
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			zero_run <= 8'h00;
			win_cnt <= 8'h00;
			ones_cnt <= 8'h00;
			signal_loss_now <= 1'b0;
		end else if (clk_en && s_strobe) begin
			if (s_bit) begin
				zero_run <= 8'h00;
			end else if (zero_run < ebi_pkg::LOS_BITS) begin
				zero_run <= zero_run + 8'h01;
			end
			if (win_cnt == ebi_pkg::LOS_BITS - 8'h01) begin
				win_cnt <= 8'h00;
				ones_cnt <= 8'h00;
				if (ones_cnt + {7'h00, s_bit} >= ebi_pkg::LOS_ONES_MIN) begin
					signal_loss_now <= 1'b0;
				end
			end else begin
				win_cnt <= win_cnt + 8'h01;
				ones_cnt <= ones_cnt + {7'h00, s_bit};
			end
			if (!s_bit && zero_run == ebi_pkg::LOS_BITS - 8'h01) begin
				signal_loss_now <= 1'b1;
			end
		end
	end

	// yellow alarm and its sticky change flag
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			myel_now <= 1'b0;
			multiframe_remote_alarm_change <= 1'b0;
		end else if (clk_en) begin
			if (ts16_fr0) begin
				myel_now <= ts16_y;
			end
			if (ts16_fr0 && ts16_y != myel_now && alarm_en[ebi_pkg::BIT_MYEL_EN]) begin
				multiframe_remote_alarm_change <= 1'b1;
			end else if (reg_read(ebi_pkg::IDX_ALARM)) begin
				multiframe_remote_alarm_change <= 1'b0;
			end
		end
	end
	assign alarm_any = ts16_fr0 && ts16_y != myel_now &&
		alarm_en[ebi_pkg::BIT_MYEL_EN];

	// enable, alarm enable, framing and mask registers are writable; irq status is write one to clear; other status bits ignore writes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			block_pending_enable <= ebi_pkg::RST_ENABLE;
		end else if (reg_write(ebi_pkg::IDX_ENABLE)) begin
			block_pending_enable <= pwdata[7:0];
		end
	end

	// bits 7 and 6 stay zero: yellow state and a reserved bit
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			alarm_en <= ebi_pkg::RST_ALARM_EN;
		end else if (reg_write(ebi_pkg::IDX_ALARM_EN)) begin
			alarm_en <= {2'h0, pwdata[5:0]};
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			alignment_loss_criterion <= ebi_pkg::RST_CRITERION;
		end else if (reg_write(ebi_pkg::IDX_FRAMING)) begin
			alignment_loss_criterion <= pwdata[2:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_mask <= ebi_pkg::RST_MASK;
		end else if (reg_write(ebi_pkg::IDX_IRQ_MASK)) begin
			irq_mask <= pwdata[7:0];
		end
	end

	assign summary = {spare_pend, 3'h0, hdlc_pend, slip_pend, alarm_pend,
		framer_pend};
	// source enables live in the sub-blocks, except alarm_en bit 5 here for the yellow change; other requests arrive pre-qualified
	assign next_irq_pin = |(summary & block_pending_enable);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_pin <= 1'b0;
		end else if (clk_en) begin
			irq_pin <= next_irq_pin;
		end
	end

	// defect states raise an event on each declare and each clear, so a
	// standing defect cannot refill its status bit right after the clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= 3'h0;
		end else if (clk_en) begin
			state_q <= {out_of_frame_now, all_ones_defect_now,
				signal_loss_now};
		end
	end
	assign state_chg = state_q ^ {out_of_frame_now, all_ones_defect_now,
		signal_loss_now};

	// sticky event status for the local interrupt, write one to clear
	assign events = {state_chg[2], state_chg[1], alarm_any, state_chg[0],
		1'b0, slip_req, alarm_src_req, framer_req};
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_status <= 8'h00;
		end else if (clk_en) begin
			if (reg_write(ebi_pkg::IDX_IRQ_STATUS)) begin
				irq_status <= events | (irq_status & ~pwdata[7:0]);
			end else begin
				irq_status <= events | irq_status;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq <= 1'b0;
		end else if (clk_en) begin
			irq <= |(irq_status & irq_mask);
		end
	end

	always_comb begin
		rd_byte = 8'h00;
		hit = 1'b1;
		case (idx)
			ebi_pkg::IDX_SUMMARY: rd_byte = summary;
			ebi_pkg::IDX_ENABLE: rd_byte = block_pending_enable;
			ebi_pkg::IDX_ALARM: rd_byte = {out_of_frame_now, all_ones_defect_now,
				multiframe_remote_alarm_change, signal_loss_now, 4'h0};
			ebi_pkg::IDX_ALARM_EN: rd_byte = alarm_en;
			ebi_pkg::IDX_FRAMING: rd_byte = {5'h00, alignment_loss_criterion};
			ebi_pkg::IDX_SLIP_ST: rd_byte = 8'h00;
			ebi_pkg::IDX_FRAMER_ST: rd_byte = 8'h00;
			ebi_pkg::IDX_ALARM_ST2: rd_byte = 8'h00;
			ebi_pkg::IDX_ALARM_ST3: rd_byte = 8'h00;
			ebi_pkg::IDX_HDLC_ST: rd_byte = 8'h00;
			ebi_pkg::IDX_IRQ_STATUS: rd_byte = irq_status;
			ebi_pkg::IDX_IRQ_MASK: rd_byte = irq_mask;
			default: hit = 1'b0;
		endcase
	end

	// no wait state: data and ready registered in the setup cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			prdata <= 32'h00000000;
			pslverr <= 1'b0;
		end else if (clk_en) begin
			pready <= psel && !pready;
			prdata <= {24'h000000, rd_byte};
			pslverr <= psel && !pready && !hit;
		end
	end
endmodule : ebi_top

// ### pkg/ebi_pkg.sv
// constants for the e1 block interrupt and alarm status logic
package ebi_pkg;
	// register word indexes; the byte address is four times the index
	localparam logic [11:0] IDX_SUMMARY = 12'hb00;
	localparam logic [11:0] IDX_ENABLE = 12'hb01;
	localparam logic [11:0] IDX_ALARM = 12'hb02;
	localparam logic [11:0] IDX_ALARM_EN = 12'hb03;
	localparam logic [11:0] IDX_FRAMING = 12'h10b;
	localparam logic [11:0] IDX_SLIP_ST = 12'hb08;
	localparam logic [11:0] IDX_FRAMER_ST = 12'hb04;
	localparam logic [11:0] IDX_ALARM_ST2 = 12'hb0e;
	localparam logic [11:0] IDX_ALARM_ST3 = 12'hb40;
	localparam logic [11:0] IDX_HDLC_ST = 12'hb06;
	localparam logic [11:0] IDX_IRQ_STATUS = 12'hc00;
	localparam logic [11:0] IDX_IRQ_MASK = 12'hc01;
	// bit positions
	localparam int BIT_SPARE = 7;
	localparam int BIT_HDLC = 3;
	localparam int BIT_SLIP = 2;
	localparam int BIT_ALARM = 1;
	localparam int BIT_FRAMER = 0;
	localparam int BIT_OOF = 7;
	localparam int BIT_AIS = 6;
	localparam int BIT_MYEL = 5;
	localparam int BIT_LOS = 4;
	localparam int BIT_MYEL_EN = 5;
	// reset values
	localparam logic [7:0] RST_ENABLE = 8'h00;
	localparam logic [7:0] RST_ALARM_EN = 8'h00;
	localparam logic [2:0] RST_CRITERION = 3'h3;
	localparam logic [7:0] RST_MASK = 8'h00;
	// counts
	localparam logic [7:0] LOS_BITS = 8'haf;
	localparam logic [7:0] LOS_ONES_MIN = 8'h16;
	localparam logic [1:0] AIS_FRAMES = 2'h2;
	localparam logic [8:0] BITS_PER_FRAME = 9'h100;
	localparam logic [1:0] AIS_ZERO_LIMIT = 2'h2;
endpackage : ebi_pkg

// ### verification/ebi_props.sv
// port checker for the e1 block interrupt logic
`timescale 1ns/1ns
module ebi_props (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic [13:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic slip_req,
	input wire logic framer_req,
	input wire logic hdlc_req,
	input wire logic spare_req,
	input wire logic alarm_src_req,
	input wire logic bit_strobe,
	input wire logic frame_start,
	input wire logic fas_check,
	input wire logic ts16_fr0,
	input wire logic irq_pin,
	input wire logic irq
);
	logic [3:0] since;
	wire act = psel | slip_req | framer_req | hdlc_req | spare_req
		| alarm_src_req | bit_strobe | frame_start | fas_check | ts16_fr0;
	wire mapped = paddr[13:2] inside {12'hb00, 12'hb01, 12'hb02, 12'hb03,
		12'h10b, 12'hb04, 12'hb06, 12'hb08, 12'hb0e, 12'hb40, 12'hc00,
		12'hc01};
	// inputs pass synchronisers, so outputs may lag their cause a little
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			since <= 4'h0;
		else if (act)
			since <= 4'h0;
		else if (since != 4'hf)
			since <= since + 4'h1;
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_rdy_wait;
		psel && penable && !pready |=> pready;
	endproperty
	a_rdy_wait: assert property (p_rdy_wait) else $error("late ready");
	property p_rdy_one;
		pready |=> !pready;
	endproperty
	a_rdy_one: assert property (p_rdy_one) else $error("long ready");
	property p_err;
		pready && !mapped |-> pslverr && prdata == 32'h0;
	endproperty
	a_err: assert property (p_err) else $error("unmapped accepted");
	property p_ok;
		pready && mapped |-> !pslverr && prdata[31:8] == 24'h0;
	endproperty
	a_ok: assert property (p_ok) else $error("mapped refused");
	property p_pin_up;
		$rose(irq_pin) |-> since < 4'h8;
	endproperty
	a_pin_up: assert property (p_pin_up) else $error("pin rose");
	property p_pin_down;
		$fell(irq_pin) |-> since < 4'h8;
	endproperty
	a_pin_down: assert property (p_pin_down) else $error("pin fell");
	property p_irq_up;
		$rose(irq) |-> since < 4'h8;
	endproperty
	a_irq_up: assert property (p_irq_up) else $error("irq rose");
	property p_irq_down;
		$fell(irq) |-> $past(psel, 1) || $past(psel, 2);
	endproperty
	a_irq_down: assert property (p_irq_down) else $error("irq fell");
	cover property (pready && pslverr);
	cover property ($rose(irq_pin));
	cover property ($rose(irq));
endmodule : ebi_props
bind ebi_top ebi_props ebi_props_i (.*);

// ### verification/testbench.sv
// self-checking bench for the e1 block interrupt logic
`timescale 1ns/1ns
module testbench;
	logic pclk = 0, presetn = 0, clk_en = 1, psel = 0, penable = 0;
	logic pwrite = 0, spare_req = 0, bit_strobe = 0, rx_bit = 0;
	logic frame_start = 0, fas_errored = 0, ts16_y = 0, err;
	logic [5:0] rq = 0;
	logic [13:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rd;
	logic pready, pslverr, irq_pin, irq;
	int fails = 0, check_count = 0, cyc = 0;
	wire framer_req = rq[0], alarm_src_req = rq[1], slip_req = rq[2];
	wire hdlc_req = rq[3], fas_check = rq[4], ts16_fr0 = rq[5];
	always #2 pclk = ~pclk;
	ebi_top ebi_top_i (.*);
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			fails++;
			test_done();
		end
	end
	task automatic test_done;
		if (fails == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : test_done
	task automatic chk(input string n, input logic [31:0] s, e);
		check_count++;
		if (s !== e) begin
			fails++;
			$display("[FAIL] %s exp %h got %h", n, e, s);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [11:0] i,
		input logic [7:0] d);
		@(posedge pclk);
		psel <= 1;
		pwrite <= w;
		paddr <= {i, 2'b00};
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask : apb
	task automatic rdc(input logic [11:0] i, input logic [7:0] e);
		apb(0, i, 8'h00);
		chk($sformatf("reg %h", i), rd, {24'h0, e});
	endtask : rdc
	task automatic req(input logic [5:0] m);
		@(posedge pclk);
		rq <= m;
		@(posedge pclk);
		rq <= 0;
	endtask : req
	// each level is held two clocks so the synchronisers cannot miss it
	task automatic bits(input logic v, input int n);
		repeat (n) begin
			@(posedge pclk);
			rx_bit <= v;
			bit_strobe <= 1;
			repeat (2) @(posedge pclk);
			bit_strobe <= 0;
			@(posedge pclk);
		end
		repeat (8) @(posedge pclk);
	endtask : bits
	task automatic frame(input int z);
		@(posedge pclk);
		frame_start <= 1;
		repeat (2) @(posedge pclk);
		frame_start <= 0;
		bits(0, z);
		bits(1, 256 - z);
	endtask : frame
	task automatic t_regs;
		rdc(12'hb00, 8'h00);
		rdc(12'hb01, 8'h00);
		rdc(12'hc01, 8'h00);
		apb(1, 12'hb00, 8'hff);
		rdc(12'hb00, 8'h00);
		apb(1, 12'hb02, 8'hff);
		rdc(12'hb02, 8'h00);
		apb(1, 12'hb01, 8'h83);
		rdc(12'hb01, 8'h83);
		apb(0, 12'h005, 8'h00);
		chk("slverr", err, 1);
		rdc(12'h10b, 8'h03);
	endtask : t_regs
	task automatic t_los;
		bits(0, 174);
		rdc(12'hb02, 8'h00);
		bits(0, 1);
		rdc(12'hb02, 8'h10);
		rdc(12'hc00, 8'h10);
		chk("irq", irq, 0);
		apb(1, 12'hc01, 8'h10);
		repeat (2) @(posedge pclk);
		chk("irq", irq, 1);
		apb(1, 12'hc00, 8'h10);
		rdc(12'hc00, 8'h00);
		chk("irq", irq, 0);
		apb(1, 12'hc01, 8'h00);
		bits(1, 175);
		rdc(12'hb02, 8'h00);
	endtask : t_los
	task automatic t_ais;
		repeat (3) frame(0);
		rdc(12'hb02, 8'h40);
		repeat (3) frame(3);
		rdc(12'hb02, 8'h00);
	endtask : t_ais
	task automatic t_yel;
		apb(1, 12'hb03, 8'h20);
		rdc(12'hb03, 8'h20);
		ts16_y <= 1;
		req(6'h20);
		rdc(12'hb00, 8'h02);
		rdc(12'hb02, 8'h20);
		rdc(12'hb02, 8'h00);
		rdc(12'hb00, 8'h00);
		ts16_y <= 0;
		req(6'h20);
		rdc(12'hb02, 8'h20);
		apb(1, 12'hb03, 8'h00);
		ts16_y <= 1;
		req(6'h20);
		rdc(12'hb02, 8'h00);
	endtask : t_yel
	task automatic t_blocks;
		apb(1, 12'hb01, 8'h00);
		req(6'h03);
		rdc(12'hb00, 8'h03);
		chk("pin", irq_pin, 0);
		apb(1, 12'hb01, 8'h01);
		repeat (2) @(posedge pclk);
		chk("pin", irq_pin, 1);
		rdc(12'hb04, 8'h00);
		rdc(12'hb00, 8'h02);
		chk("pin", irq_pin, 0);
		apb(1, 12'hb01, 8'h02);
		repeat (2) @(posedge pclk);
		chk("pin", irq_pin, 1);
		rdc(12'hb40, 8'h00);
		rdc(12'hb00, 8'h00);
		chk("pin", irq_pin, 0);
		req(6'h0c);
		rdc(12'hb00, 8'h0c);
		rdc(12'hb08, 8'h00);
		rdc(12'hb00, 8'h08);
		rdc(12'hb06, 8'h00);
		rdc(12'hb00, 8'h00);
	endtask : t_blocks
	task automatic t_spare;
		spare_req <= 1;
		repeat (3) @(posedge pclk);
		chk("pin", irq_pin, 0);
		rdc(12'hb00, 8'h80);
		apb(1, 12'hb01, 8'h80);
		repeat (2) @(posedge pclk);
		chk("pin", irq_pin, 1);
		spare_req <= 0;
		repeat (4) @(posedge pclk);
		chk("pin", irq_pin, 0);
	endtask : t_spare
	task automatic t_oof;
		fas_errored <= 1;
		req(6'h10);
		req(6'h10);
		rdc(12'hb02, 8'h00);
		req(6'h10);
		rdc(12'hb02, 8'h80);
	endtask : t_oof
	// a request that arrives while the clock enable is low must be lost
	task automatic t_freeze;
		@(posedge pclk);
		clk_en <= 0;
		req(6'h01);
		repeat (2) @(posedge pclk);
		clk_en <= 1;
		rdc(12'hb00, 8'h00);
	endtask : t_freeze
	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1;
		t_regs();
		t_los();
		t_ais();
		t_yel();
		t_blocks();
		t_spare();
		t_oof();
		t_freeze();
		test_done();
	end
endmodule : testbench
